// >>> verilog/motor_pwm_pkg.sv
// Purpose: shared constants and types for the motor pwm timing block
// Assumes: one 250 MHz clock; slower rates are enable pulses
// Notes: dead time and delays count 60 MHz bus ticks
package motor_pwm_pkg;
    localparam int CLK_MHZ = 250;
    localparam int BUS_MHZ = 60;
    localparam int OSC_MHZ = 48;
    localparam int CONV_MHZ = OSC_MHZ / 2;
    localparam int CAL_DIV = 4;
    localparam logic [1:0] CAL_LAST = 2'(CAL_DIV - 1);
    // -3000 and 2999 in two's complement
    localparam logic [13:0] CNT_INIT = 14'h3448;
    localparam logic [13:0] CNT_FINAL = 14'h0BB7;
    localparam int DEAD_NS = 500;
    localparam logic [5:0] DEAD_TICKS = 6'(BUS_MHZ * DEAD_NS / 1000);
    localparam logic [15:0] PRE0_TICKS = 16'(BUS_MHZ * DEAD_NS / 2000);
    localparam logic [3:0] CONV_TICKS = 4'hE;
    localparam logic [4:0] AVG_LAST = 5'h1F;
    localparam int AVG_SHIFT = 5;
    localparam logic [5:0] DAC_REF = 6'h3E;
    localparam logic [3:0] SLOW_LAST = 4'hF;
    localparam logic [6:0] HALL_LAST = 7'h7F;
    localparam logic [15:0] CNT16_MAX = 16'hFFFF;

    typedef struct packed {
        logic high;
        logic low;
    } gate_pair_s;

    typedef struct packed {
        logic start;
        logic bus_sel;
    } conv_req_s;

    typedef enum logic {POS_ENCODER, POS_HALL} pos_mode_e;
    typedef enum logic [1:0] {CV_IDLE, CV_CURRENT, CV_BUS, CV_CAL} conv_state_e;
endpackage

// >>> verilog/rate_enable.sv
// Purpose: fractional divider giving an average NUM/DEN enable rate
// Assumes: DEN below 256
// Notes: tick jitters by one clock; average rate is exact
`timescale 1ns/1ns
module rate_enable #(
    parameter int unsigned NUM = 1,
    parameter int unsigned DEN = 2
) (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // enable out
    output logic tick
);
    logic [7:0] acc_q;
    wire [8:0] sum = {1'b0, acc_q} + 9'(NUM);
    wire wrap = sum >= 9'(DEN);
    wire [8:0] rem = sum - 9'(DEN);

    always_ff @(posedge clk) begin
        if (reset) begin
            acc_q <= 8'h00;
            tick <= 1'b0;
        end else begin
            acc_q <= wrap ? rem[7:0] : sum[7:0];
            tick <= wrap;
        end
    end
endmodule // rate_enable

// >>> verilog/dead_time_pair.sv
// Purpose: one complementary gate pair with dead time and shutoff
// Assumes: tick is the bus-rate enable
// Notes: a raw change during dead time restarts the gap
`timescale 1ns/1ns
module dead_time_pair (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // control
    input wire logic tick,
    input wire logic raw,
    input wire logic off,
    // gates
    output motor_pwm_pkg::gate_pair_s gates
);
    logic raw_q;
    logic [5:0] dead_q;
    wire settled = dead_q == 6'h00;

    always_ff @(posedge clk) begin
        if (reset) begin
            raw_q <= 1'b0;
            dead_q <= motor_pwm_pkg::DEAD_TICKS;
            gates <= '0;
        end else begin
            if (tick && raw != raw_q) begin
                raw_q <= raw;
                dead_q <= motor_pwm_pkg::DEAD_TICKS;
            end else if (tick && !settled) begin
                dead_q <= dead_q - 6'h01;
            end
            gates.high <= raw_q & settled & ~off;
            gates.low <= ~raw_q & settled & ~off;
        end
    end
endmodule // dead_time_pair

// >>> verilog/motor_pwm_adc_sync.sv
// Purpose: pwm, trigger delay, converter, slow loop and position timing
// Assumes: pins pass two flops; software strobes are on clk
// Notes: bus and converter rates are enables from fractional dividers
`timescale 1ns/1ns
module motor_pwm_adc_sync (
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // pwm duty, taken at reload
    input wire logic [2:0][13:0] duty_compare,
    // fault pins
    input wire logic fault_input_one,
    input wire logic overcurrent_comparator,
    // gate driver
    output motor_pwm_pkg::gate_pair_s [2:0] gate_pairs,
    output logic [1:0] masked_channels,
    output logic [5:0] comparator_reference_dac,
    output logic fault_active,
    // trigger delay unit
    input wire logic [15:0] interrupt_delay_value,
    input wire logic reload_trigger_disable,
    input wire logic delay_point_ack,
    input wire logic seq_error_clear,
    output logic reload_trigger,
    output logic reload_trigger_enabled,
    output logic delay_point_flag,
    output logic seq_error_flag,
    output logic delay_unit_irq,
    // converters a and b
    input wire logic [1:0][11:0] analog_sample,
    input wire logic [1:0][1:0] result_read,
    input wire logic calibrate_start,
    input wire logic fast_loop_ack,
    output motor_pwm_pkg::conv_req_s [1:0] conv_req,
    output logic [1:0][1:0][11:0] conv_result,
    output logic [1:0][11:0] cal_average,
    output logic [1:0] calibrating,
    output logic fast_loop_irq,
    // slow loop timer
    input wire logic [15:0] slow_loop_period,
    output logic slow_loop_irq,
    // position timer
    input wire motor_pwm_pkg::pos_mode_e position_mode,
    input wire logic [15:0] encoder_pulses,
    input wire logic encoder_a,
    input wire logic encoder_b,
    input wire logic [2:0] hall_sensor,
    output logic [15:0] position_count,
    output logic [15:0] hall_capture,
    output logic hall_capture_irq
);
    // pin synchronisers
    logic [6:0] pin_meta_q;
    logic [6:0] pin_q;
    wire [6:0] pins = {hall_sensor, encoder_b, encoder_a, overcurrent_comparator, fault_input_one};
    wire fault_s = pin_q[0];
    wire cmp_s = pin_q[1];
    wire enc_a_s = pin_q[2];
    wire enc_b_s = pin_q[3];
    wire [2:0] hall_s = pin_q[6:4];

    always_ff @(posedge clk) begin
        if (reset) begin
            pin_meta_q <= '0;
            pin_q <= '0;
        end else begin
            pin_meta_q <= pins;
            pin_q <= pin_meta_q;
        end
    end

    // rate enables
    logic bus_tick;
    logic conv_tick;
    rate_enable #(.NUM(motor_pwm_pkg::BUS_MHZ), .DEN(motor_pwm_pkg::CLK_MHZ)) u_bus_rate (
        .clk(clk),
        .reset(reset),
        .tick(bus_tick)
    );
    rate_enable #(.NUM(motor_pwm_pkg::CONV_MHZ), .DEN(motor_pwm_pkg::CLK_MHZ)) u_conv_rate (
        .clk(clk),
        .reset(reset),
        .tick(conv_tick)
    );

    // pwm counter
    logic [13:0] cnt_q;
    logic [2:0][13:0] duty_q;
    logic fault_active_q;
    logic [2:0] pwm_raw;
    wire at_final = cnt_q == motor_pwm_pkg::CNT_FINAL;
    wire reload = bus_tick & at_final;

    always_ff @(posedge clk) begin
        if (reset) begin
            cnt_q <= motor_pwm_pkg::CNT_INIT;
            duty_q <= {3{motor_pwm_pkg::CNT_INIT}};
        end else if (bus_tick) begin
            cnt_q <= at_final ? motor_pwm_pkg::CNT_INIT : cnt_q + 14'h0001;
            if (at_final) begin
                duty_q <= duty_compare;
            end
        end
    end

    for (genvar p = 0; p < 3; p++) begin : g_pair
        assign pwm_raw[p] = $signed(cnt_q) < $signed(duty_q[p]);
        dead_time_pair u_pair (
            .clk(clk),
            .reset(reset),
            .tick(bus_tick),
            .raw(pwm_raw[p]),
            .off(fault_active_q),
            .gates(gate_pairs[p])
        );
    end
    assign masked_channels = 2'h0;

    // comparator filter and fault latch
    logic [3:0] cmp_hist_q;
    logic cmp_filt_q;
    assign comparator_reference_dac = motor_pwm_pkg::DAC_REF;
    wire fault_now = fault_s | cmp_filt_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            cmp_hist_q <= 4'h0;
            cmp_filt_q <= 1'b0;
            fault_active_q <= 1'b0;
        end else begin
            if (bus_tick) begin
                cmp_hist_q <= {cmp_hist_q[2:0], cmp_s};
                if (&cmp_hist_q) begin
                    cmp_filt_q <= 1'b1;
                end else if (~|cmp_hist_q) begin
                    cmp_filt_q <= 1'b0;
                end
            end
            if (fault_now) begin
                fault_active_q <= 1'b1;
            end else if (reload) begin
                fault_active_q <= 1'b0;
            end
        end
    end
    assign fault_active = fault_active_q;

    // trigger delay unit; counter parks at max so nothing fires before the first trigger
    logic trig_en_q;
    logic trig_q;
    logic dly_flag_q;
    logic seq_err_q;
    logic fast_irq_q;
    logic [15:0] dly_cnt_q;
    logic [1:0] seq_set;
    logic [1:0] done_cur;
    wire fire = reload & trig_en_q;
    wire dly_hit = bus_tick & (dly_cnt_q == interrupt_delay_value);
    wire pre0 = bus_tick & (dly_cnt_q == motor_pwm_pkg::PRE0_TICKS);
    wire dly_run = bus_tick & (dly_cnt_q != motor_pwm_pkg::CNT16_MAX);

    always_ff @(posedge clk) begin
        if (reset) begin
            trig_en_q <= 1'b1;
            trig_q <= 1'b0;
            dly_flag_q <= 1'b0;
            seq_err_q <= 1'b0;
            fast_irq_q <= 1'b0;
            dly_cnt_q <= motor_pwm_pkg::CNT16_MAX;
        end else begin
            trig_q <= fire;
            if (fire) begin
                dly_cnt_q <= 16'h0000;
            end else if (dly_run) begin
                dly_cnt_q <= dly_cnt_q + 16'h0001;
            end
            if (dly_hit) begin
                trig_en_q <= 1'b1;
            end else if (reload_trigger_disable) begin
                trig_en_q <= 1'b0;
            end
            if (dly_hit) begin
                dly_flag_q <= 1'b1;
            end else if (delay_point_ack) begin
                dly_flag_q <= 1'b0;
            end
            if (|seq_set) begin
                seq_err_q <= 1'b1;
            end else if (seq_error_clear) begin
                seq_err_q <= 1'b0;
            end
            if (done_cur[0]) begin
                fast_irq_q <= 1'b1;
            end else if (fast_loop_ack) begin
                fast_irq_q <= 1'b0;
            end
        end
    end
    assign reload_trigger = trig_q;
    assign reload_trigger_enabled = trig_en_q;
    assign delay_point_flag = dly_flag_q;
    assign seq_error_flag = seq_err_q;
    assign fast_loop_irq = fast_irq_q;
    // held off while converter interrupt pends
    assign delay_unit_irq = (dly_flag_q | seq_err_q) & ~fast_irq_q;

    // converters
    logic [1:0] cal_div_q;
    wire slow_conv = conv_tick & (cal_div_q == motor_pwm_pkg::CAL_LAST);

    always_ff @(posedge clk) begin
        if (reset) begin
            cal_div_q <= 2'h0;
        end else if (conv_tick) begin
            cal_div_q <= cal_div_q + 2'h1;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_conv
        motor_pwm_pkg::conv_state_e st_q;
        logic [3:0] left_q;
        logic [11:0] hold_q;
        logic [1:0] valid_q;
        logic [1:0][11:0] res_q;
        logic [11:0] avg_q;
        logic [4:0] avg_n_q;
        logic [16:0] acc_q;
        logic req_q;
        logic sel_q;
        wire in_cal = st_q == motor_pwm_pkg::CV_CAL;
        wire busy = st_q != motor_pwm_pkg::CV_IDLE;
        wire ctick = in_cal ? slow_conv : conv_tick;
        wire done = busy & ctick & (left_q == 4'h1);
        wire start0 = pre0 & ~busy;
        wire done_bus = done & (st_q == motor_pwm_pkg::CV_BUS);
        wire done_cal = done & in_cal;
        wire cal_end = done_cal & (avg_n_q == motor_pwm_pkg::AVG_LAST);
        wire cal_go = calibrate_start & ~busy & ~start0;
        wire load = start0 | cal_go | done_cur[c] | (done_cal & ~cal_end);
        wire [16:0] acc_next = acc_q + 17'(hold_q);
        assign done_cur[c] = done & (st_q == motor_pwm_pkg::CV_CURRENT);
        assign seq_set[c] = (start0 & valid_q[0]) | (done_cur[c] & valid_q[1]);

        always_ff @(posedge clk) begin
            if (reset) begin
                st_q <= motor_pwm_pkg::CV_IDLE;
                left_q <= 4'h0;
                hold_q <= 12'h000;
                valid_q <= 2'h0;
                res_q <= '0;
                avg_q <= 12'h000;
                avg_n_q <= 5'h00;
                acc_q <= 17'h00000;
                req_q <= 1'b0;
                sel_q <= 1'b0;
            end else begin
                // bus voltage chained back to back
                req_q <= start0 | done_cur[c];
                sel_q <= done_cur[c];
                if (load) begin
                    hold_q <= analog_sample[c];
                    left_q <= motor_pwm_pkg::CONV_TICKS;
                end else if (busy && ctick) begin
                    left_q <= left_q - 4'h1;
                end
                unique case (st_q)
                    motor_pwm_pkg::CV_IDLE: begin
                        if (start0) begin
                            st_q <= motor_pwm_pkg::CV_CURRENT;
                        end else if (cal_go) begin
                            st_q <= motor_pwm_pkg::CV_CAL;
                        end
                    end
                    motor_pwm_pkg::CV_CURRENT: begin
                        if (done) begin
                            st_q <= motor_pwm_pkg::CV_BUS;
                        end
                    end
                    motor_pwm_pkg::CV_BUS: begin
                        if (done) begin
                            st_q <= motor_pwm_pkg::CV_IDLE;
                        end
                    end
                    motor_pwm_pkg::CV_CAL: begin
                        if (cal_end) begin
                            st_q <= motor_pwm_pkg::CV_IDLE;
                        end
                    end
                endcase
                if (done_cur[c]) begin
                    res_q[0] <= hold_q;
                end
                if (done_bus) begin
                    res_q[1] <= hold_q;
                end
                valid_q[0] <= done_cur[c] | (valid_q[0] & ~result_read[c][0]);
                valid_q[1] <= done_bus | (valid_q[1] & ~result_read[c][1]);
                if (cal_go) begin
                    acc_q <= 17'h00000;
                    avg_n_q <= 5'h00;
                end else if (done_cal) begin
                    acc_q <= acc_next;
                    avg_n_q <= avg_n_q + 5'h01;
                end
                if (cal_end) begin
                    avg_q <= 12'(acc_next >> motor_pwm_pkg::AVG_SHIFT);
                end
            end
        end
        assign conv_req[c].start = req_q;
        assign conv_req[c].bus_sel = sel_q;
        assign conv_result[c] = res_q;
        assign cal_average[c] = avg_q;
        assign calibrating[c] = in_cal;
    end

    // slow loop timer
    logic [3:0] slow_pre_q;
    logic [15:0] slow_cnt_q;
    logic slow_irq_q;
    wire slow_tick = bus_tick & (slow_pre_q == motor_pwm_pkg::SLOW_LAST);
    wire slow_wrap = slow_tick & (slow_cnt_q >= slow_loop_period);

    always_ff @(posedge clk) begin
        if (reset) begin
            slow_pre_q <= 4'h0;
            slow_cnt_q <= 16'h0000;
            slow_irq_q <= 1'b0;
        end else begin
            if (bus_tick) begin
                slow_pre_q <= slow_pre_q + 4'h1;
            end
            if (slow_tick) begin
                slow_cnt_q <= slow_wrap ? 16'h0000 : slow_cnt_q + 16'h0001;
            end
            slow_irq_q <= slow_wrap;
        end
    end
    assign slow_loop_irq = slow_irq_q;

    // position timer; no halt input, so it keeps counting under debug halt
    logic [6:0] hall_pre_q;
    logic [15:0] pos_q;
    logic [15:0] cap_q;
    logic hall_x_q;
    logic enc_a_q;
    logic enc_b_q;
    logic cap_irq_q;
    wire hall_x = ^hall_s;
    wire hall_edge = hall_x ^ hall_x_q;
    wire hall_tick = bus_tick & (hall_pre_q == motor_pwm_pkg::HALL_LAST);
    wire is_hall = position_mode == motor_pwm_pkg::POS_HALL;
    // wrap at four times pulses minus one
    wire [15:0] enc_last = {encoder_pulses[13:0], 2'h0} - 16'h0001;
    wire enc_step = enc_a_s ^ enc_a_q ^ enc_b_s ^ enc_b_q;
    wire enc_up = enc_a_s ^ enc_b_q;
    wire [15:0] enc_inc = (pos_q >= enc_last) ? 16'h0000 : pos_q + 16'h0001;
    wire [15:0] enc_dec = (pos_q == 16'h0000) ? enc_last : pos_q - 16'h0001;

    always_ff @(posedge clk) begin
        if (reset) begin
            hall_pre_q <= 7'h00;
            pos_q <= 16'h0000;
            cap_q <= 16'h0000;
            hall_x_q <= 1'b0;
            enc_a_q <= 1'b0;
            enc_b_q <= 1'b0;
            cap_irq_q <= 1'b0;
        end else begin
            hall_x_q <= hall_x;
            enc_a_q <= enc_a_s;
            enc_b_q <= enc_b_s;
            if (bus_tick) begin
                hall_pre_q <= hall_pre_q + 7'h01;
            end
            cap_irq_q <= is_hall & hall_edge;
            if (is_hall && hall_edge) begin
                cap_q <= pos_q;
                pos_q <= 16'h0000;
            end else if (is_hall && hall_tick) begin
                pos_q <= pos_q + 16'h0001;
            end else if (!is_hall && enc_step) begin
                pos_q <= enc_up ? enc_inc : enc_dec;
            end
        end
    end
    assign position_count = pos_q;
    assign hall_capture = cap_q;
    assign hall_capture_irq = cap_irq_q;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire [2:0] gate_hi = {gate_pairs[2].high, gate_pairs[1].high, gate_pairs[0].high};
    wire [2:0] gate_lo = {gate_pairs[2].low, gate_pairs[1].low, gate_pairs[0].low};

    property p_cnt_range;
        $signed(cnt_q) >= $signed(motor_pwm_pkg::CNT_INIT) && $signed(cnt_q) <= $signed(motor_pwm_pkg::CNT_FINAL);
    endproperty
    a_cnt_range: assert property (p_cnt_range) else $error("pwm count out of range");
    property p_reload_init;
        reload |=> cnt_q == motor_pwm_pkg::CNT_INIT;
    endproperty
    a_reload_init: assert property (p_reload_init) else $error("no wrap to initial value");
    property p_dead_gap;
        $fell(gate_lo[0]) |=> !gate_hi[0] [*8];
    endproperty
    a_dead_gap: assert property (p_dead_gap) else $error("dead time too short");
    property p_fault_off;
        fault_active_q |=> (gate_hi == 3'h0) && (gate_lo == 3'h0);
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("gates on during fault");
    property p_fault_hold;
        fault_active_q && !reload |=> fault_active_q;
    endproperty
    a_fault_hold: assert property (p_fault_hold) else $error("fault cleared off reload");
    property p_fire_reset;
        fire |=> reload_trigger && dly_cnt_q == 16'h0000;
    endproperty
    a_fire_reset: assert property (p_fire_reset) else $error("trigger did not reset counter");
    property p_pre0;
        fire && !calibrating[0] |-> ##[58:70] conv_req[0].start;
    endproperty
    a_pre0: assert property (p_pre0) else $error("first pretrigger late");
    property p_chain;
        done_cur[0] |=> conv_req[0].start && conv_req[0].bus_sel;
    endproperty
    a_chain: assert property (p_chain) else $error("bus pretrigger not chained");
    property p_fast;
        done_cur[0] |=> fast_loop_irq;
    endproperty
    a_fast: assert property (p_fast) else $error("fast loop interrupt missing");
    property p_reen;
        dly_hit |=> reload_trigger_enabled && delay_point_flag;
    endproperty
    a_reen: assert property (p_reen) else $error("trigger not reenabled");
    property p_prio;
        fast_loop_irq |-> !delay_unit_irq;
    endproperty
    a_prio: assert property (p_prio) else $error("delay interrupt outranks converter");
    property p_seq;
        |seq_set |=> seq_error_flag && (fast_loop_irq || delay_unit_irq);
    endproperty
    a_seq: assert property (p_seq) else $error("sequence error not flagged");

    c_fault_recover: cover property (fault_active_q ##1 !fault_active_q);
    c_chain: cover property (done_cur[0] ##1 conv_req[0].start);
    c_seq: cover property (|seq_set);
    c_hall: cover property (hall_capture_irq);
endmodule // motor_pwm_adc_sync

// >>> tb/inverter_model.sv
// Purpose: gate driver and sensor stand-in
// Assumes: bench commands fault, hall and sample levels
// Notes: overlap is sticky so a short shoot-through is not lost
`timescale 1ns/1ns
module inverter_model (
    // clock
    input wire logic clk,
    // gates and commands
    input wire motor_pwm_pkg::gate_pair_s [2:0] gates,
    input wire logic fault_cmd,
    input wire logic [2:0] hall_cmd,
    input wire logic [11:0] level,
    // pins
    output logic fault_pin,
    output logic [2:0] hall_pin,
    output logic [1:0][11:0] sample,
    output logic overlap
);
    assign fault_pin = fault_cmd;
    assign hall_pin = hall_cmd;
    assign sample = {~level, level};
    initial overlap = 1'b0;
    // no shoot-through
    // unknown gates before the first edge must not latch an overlap
    always @(posedge clk) begin
        if ((|{gates[0].high & gates[0].low, gates[1].high & gates[1].low,
            gates[2].high & gates[2].low}) === 1'b1) begin
            overlap <= 1'b1;
        end
    end
endmodule // inverter_model

// >>> tb/tb.sv
// Purpose: self-checking bench for the motor pwm timing block
// Assumes: inputs change at the falling edge
// Notes: delay point set near so one period covers the fast loop
`timescale 1ns/1ns
module tb;
    logic clk = 0, reset = 1, fault_cmd = 0, trig_off = 0, fack = 0, fl_q = 0, overlap, fault_pin;
    logic ocmp = 0, dack = 0, sclr = 0, enc_a = 0, enc_b = 0;
    logic [2:0][13:0] duty = {3{14'h3448}};
    motor_pwm_pkg::pos_mode_e pmode = motor_pwm_pkg::POS_ENCODER;
    logic [2:0] hall_cmd = 0, hall_pin;
    logic [11:0] level = 0;
    logic [1:0][11:0] sample, cal_average;
    motor_pwm_pkg::gate_pair_s [2:0] gate_pairs;
    motor_pwm_pkg::conv_req_s [1:0] conv_req;
    logic [1:0][1:0][11:0] conv_result;
    logic [1:0] masked_channels, calibrating;
    logic [5:0] comparator_reference_dac;
    logic [15:0] position_count, hall_capture;
    logic fault_active, reload_trigger, reload_trigger_enabled, delay_point_flag, seq_error_flag;
    logic delay_unit_irq, fast_loop_irq, slow_loop_irq, hall_capture_irq;
    logic [11:0] exp_q[$];
    int fail_count = 0, checked = 0, n;
    initial forever #2 clk = ~clk;
    motor_pwm_adc_sync motor_pwm_adc_sync_inst (.clk(clk), .reset(reset), .duty_compare(duty),
        .fault_input_one(fault_pin), .overcurrent_comparator(ocmp), .gate_pairs(gate_pairs),
        .masked_channels(masked_channels), .comparator_reference_dac(comparator_reference_dac),
        .fault_active(fault_active), .interrupt_delay_value(16'h0064), .reload_trigger_disable(trig_off),
        .delay_point_ack(dack), .seq_error_clear(sclr), .reload_trigger(reload_trigger),
        .reload_trigger_enabled(reload_trigger_enabled), .delay_point_flag(delay_point_flag),
        .seq_error_flag(seq_error_flag), .delay_unit_irq(delay_unit_irq), .analog_sample(sample),
        .result_read(4'h0), .calibrate_start(1'b0), .fast_loop_ack(fack), .conv_req(conv_req),
        .conv_result(conv_result), .cal_average(cal_average), .calibrating(calibrating),
        .fast_loop_irq(fast_loop_irq), .slow_loop_period(16'h0003), .slow_loop_irq(slow_loop_irq),
        .position_mode(pmode), .encoder_pulses(16'h0010), .encoder_a(enc_a),
        .encoder_b(enc_b), .hall_sensor(hall_pin), .position_count(position_count),
        .hall_capture(hall_capture), .hall_capture_irq(hall_capture_irq));
    inverter_model inverter_model_inst (.clk(clk), .gates(gate_pairs), .fault_cmd(fault_cmd),
        .hall_cmd(hall_cmd), .level(level), .fault_pin(fault_pin), .hall_pin(hall_pin),
        .sample(sample), .overlap(overlap));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(ref logic s);
        n = 0;
        while (s !== 1'b1 && n < 40000) begin
            @(negedge clk);
            n++;
        end
        chk(s, 1);
    endtask
    task automatic results;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // the watcher pairs each new fast loop result with the oldest note
    always @(negedge clk) begin
        if (fast_loop_irq === 1'b1 && !fl_q) chk(conv_result[0][0], exp_q.pop_front());
        fl_q = (fast_loop_irq === 1'b1);
    end
    initial begin
        repeat (90000) @(posedge clk);
        fail_count++;
        results();
    end
    initial begin
        void'($urandom(32'h2CDC));
        repeat (16) @(negedge clk);
        reset = 0;
        chk(comparator_reference_dac, 16'h003E);
        chk(masked_channels, 16'h0000);
        enc_b = 1;
        repeat (4) @(negedge clk);
        chk(position_count, 16'h003F);
        enc_b = 0;
        repeat (4) @(negedge clk);
        chk(position_count, 16'h0000);
        wt(slow_loop_irq);
        @(negedge clk);
        n = 0;
        while (slow_loop_irq !== 1'b1 && n < 400) begin
            @(negedge clk);
            n++;
        end
        chk(n inside {[264:267]}, 1);
        level = 12'($urandom);
        exp_q.push_back(level);
        wt(reload_trigger);
        n = 0;
        while (conv_req[0].start !== 1'b1 && n < 200) begin
            @(negedge clk);
            n++;
        end
        chk(n inside {[55:72]}, 1);
        wt(fast_loop_irq);
        chk(conv_req[0], 16'h0003);
        trig_off = 1;
        @(negedge clk);
        trig_off = 0;
        @(negedge clk);
        chk(reload_trigger_enabled, 0);
        wt(delay_point_flag);
        @(negedge clk);
        chk(reload_trigger_enabled, 1);
        chk(delay_unit_irq, 0);
        fack = 1;
        @(negedge clk);
        fack = 0;
        repeat (2) @(negedge clk);
        chk(delay_unit_irq, 1);
        ocmp = 1;
        repeat (2) @(negedge clk);
        ocmp = 0;
        repeat (30) @(negedge clk);
        chk(fault_active, 0);
        fault_cmd = 1;
        repeat (6) @(negedge clk);
        chk({fault_active, gate_pairs}, 16'h0040);
        fault_cmd = 0;
        duty = '0;
        exp_q.push_back(level);
        wt(reload_trigger);
        repeat (200) @(negedge clk);
        chk({fault_active, gate_pairs}, 16'h002A);
        chk(seq_error_flag, 1);
        pmode = motor_pwm_pkg::POS_HALL;
        for (int p = 0; p < 3; p++) begin
            hall_cmd[p] = 1;
            wt(hall_capture_irq);
            repeat (2) @(negedge clk);
        end
        ocmp = 1;
        repeat (40) @(negedge clk);
        chk({fault_active, gate_pairs}, 16'h0040);
        wt(delay_point_flag);
        {dack, sclr} = 2'h3;
        @(negedge clk);
        {dack, sclr} = 2'h0;
        @(negedge clk);
        chk({delay_point_flag, seq_error_flag, delay_unit_irq}, 16'h0000);
        chk(overlap, 0);
        results();
    end
endmodule // tb
